// ==== verilog/xadld_pkg.sv ====
package xadld_pkg;
	// ==========================================
	// Instruction word layout
	// ==========================================
	localparam int unsigned XADLD_IW = 14;
	localparam logic [13:0] XADLD_LDIR_MASK = 14'h3ff8;
	localparam logic [13:0] XADLD_LDIR_CODE = 14'h0060;
	localparam logic [2:0] XADLD_LDIR_MIN = 3'h5;
	localparam logic [2:0] XADLD_LDIR_MAX = 3'h7;
	localparam logic [5:0] XADLD_XLIT_OP = 6'h3a;
	localparam logic [5:0] XADLD_XREG_OP = 6'h06;
	localparam int unsigned XADLD_OP_LSB = 8;
	localparam int unsigned XADLD_DEST_BIT = 7;
	// ==========================================
	// Direction register file addresses and reset values
	// ==========================================
	localparam logic [6:0] XADLD_DIR_BASE = 7'h05;
	localparam logic [6:0] XADLD_DIR_FILE_BASE = 7'h05;
	localparam logic [7:0] XADLD_DIR_RESET = 8'hff;
	localparam logic [7:0] XADLD_W_RESET = 8'h00;
	localparam int unsigned XADLD_NUM_DIR = 3;
	localparam int unsigned XADLD_QPHASES = 4;
	typedef enum logic [1:0] {XADLD_Q1, XADLD_Q2, XADLD_Q3, XADLD_Q4} xadld_q_e;
endpackage : xadld_pkg

// ==== verilog/xadld_dir_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module xadld_dir_reg (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic [7:0] data_in,
	output logic [7:0] value_out
);
	import xadld_pkg::*;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			value_out <= XADLD_DIR_RESET;
		end else if (load_in) begin
			value_out <= data_in;
		end
	end
endmodule : xadld_dir_reg
`default_nettype wire

// ==== verilog/xadld_core.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01: Direction-load copies W into direction register 5..7; one cycle, flags untouched.
// RULE_02: Direction registers also readable and writable as ordinary file registers.
// RULE_03: Literal XOR places W xor 8-bit literal into W.
// RULE_04: Register XOR combines W with file register and updates zero flag.
// RULE_05: Destination bit clear writes W, set writes the file register.
// RULE_06: Each instruction: decode Q1, read Q2, process Q3, write Q4.
// RULE_07: Literal XOR also sets zero flag when result is zero.
module xadld_core (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic instr_valid_in,
	input wire logic [13:0] instr_in,
	input wire logic [7:0] file_rdata_in,
	input wire logic file_wr_in,
	input wire logic [6:0] file_waddr_in,
	input wire logic [7:0] file_wdata_in,
	output logic [6:0] file_raddr_out,
	output logic file_rd_out,
	output logic file_we_out,
	output logic [6:0] file_waddr_out,
	output logic [7:0] file_wdata_out,
	output logic [7:0] w_out,
	output logic zero_flag_out,
	output logic [23:0] dir_regs_out,
	output logic [7:0] dir_rdata_out,
	output logic [1:0] q_phase_out,
	output logic done_out
);
	import xadld_pkg::*;
	// ==========================================
	// Reset release
	// ==========================================
	logic rst_meta_reg;
	logic rst_n_reg;
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end
	// ==========================================
	// Quarter-phase sequencer
	// ==========================================
	xadld_q_e q_reg;
	xadld_q_e q_next;
	logic [13:0] ir_reg;
	logic busy_reg;
	logic [7:0] opnd_reg;
	logic [7:0] res_reg;
	always_comb begin
		case (q_reg)
			XADLD_Q1: q_next = busy_reg ? XADLD_Q2 : XADLD_Q1;
			XADLD_Q2: q_next = XADLD_Q3;
			XADLD_Q3: q_next = XADLD_Q4;
			XADLD_Q4: q_next = XADLD_Q1;
			default: q_next = XADLD_Q1;
		endcase
	end
	// ==========================================
	// Decode
	// ==========================================
	wire [5:0] op_w = ir_reg[13:XADLD_OP_LSB];
	wire [2:0] dsel_w = ir_reg[2:0];
	wire is_ldir_w = ((ir_reg & XADLD_LDIR_MASK) == XADLD_LDIR_CODE)
		&& (dsel_w >= XADLD_LDIR_MIN) && (dsel_w <= XADLD_LDIR_MAX);
	wire is_xlit_w = (op_w == XADLD_XLIT_OP);
	wire is_xreg_w = (op_w == XADLD_XREG_OP);
	wire dest_file_w = ir_reg[XADLD_DEST_BIT];
	wire [6:0] faddr_w = ir_reg[6:0];
	wire start_w = (q_reg == XADLD_Q1) && !busy_reg && instr_valid_in;
	wire q2_w = busy_reg && (q_reg == XADLD_Q2);
	wire q3_w = busy_reg && (q_reg == XADLD_Q3);
	wire q4_w = busy_reg && (q_reg == XADLD_Q4);
	// Direction registers sit at file addresses 5..7 for ordinary access.
	wire [6:0] dir_rel_w = file_raddr_out - XADLD_DIR_FILE_BASE;
	wire dir_rd_hit_w = (file_raddr_out >= XADLD_DIR_FILE_BASE) && (dir_rel_w < 7'(XADLD_NUM_DIR));
	wire [7:0] rd_src_w = dir_rd_hit_w ? dir_regs_out[8*dir_rel_w[1:0] +: 8] : file_rdata_in; // RULE_02
	wire [7:0] xsrc_w = is_xlit_w ? ir_reg[7:0] : opnd_reg;
	wire [7:0] xres_w = w_out ^ xsrc_w; // RULE_03 RULE_04
	wire res_to_w_w = is_xlit_w || (is_xreg_w && !dest_file_w); // RULE_05
	wire res_to_f_w = is_xreg_w && dest_file_w; // RULE_05
	wire decode_w = busy_reg && (q_reg == XADLD_Q1);
	wire rd_req_w = decode_w && is_xreg_w;
	wire wr_w_w = q4_w && res_to_w_w; // RULE_05
	wire wr_f_w = q4_w && res_to_f_w; // RULE_05
	wire wr_z_w = q4_w && (is_xlit_w || is_xreg_w); // RULE_04 RULE_07
	wire [1:0] q_code_w = q_reg;

	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			q_reg <= XADLD_Q1;
		end else begin
			q_reg <= q_next; // RULE_06
		end
	end

	// The word is latched at the take, so the caller may drop it at once.
	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			busy_reg <= 1'b0;
			ir_reg <= '0;
		end else if (start_w) begin
			busy_reg <= 1'b1;
			ir_reg <= instr_in;
		end else if (q4_w) begin
			busy_reg <= 1'b0;
		end
	end

	// ==========================================
	// Operand read, process, write
	// ==========================================
	// The read request stands through Q2, so the operand is sampled while the file still drives it.
	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			file_raddr_out <= '0;
			file_rd_out <= 1'b0;
		end else begin
			file_rd_out <= rd_req_w;
			if (decode_w) begin
				file_raddr_out <= faddr_w;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			opnd_reg <= '0;
		end else if (q2_w) begin
			opnd_reg <= rd_src_w; // RULE_06
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			res_reg <= '0;
		end else if (q3_w) begin
			res_reg <= xres_w; // RULE_06
		end
	end

	// ==========================================
	// Write back
	// ==========================================
	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			w_out <= XADLD_W_RESET;
		end else if (wr_w_w) begin
			w_out <= res_reg; // RULE_03 RULE_05
		end
	end

	// A direction load never enables this flag, so it keeps its value across one.
	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			zero_flag_out <= 1'b0;
		end else if (wr_z_w) begin
			zero_flag_out <= (res_reg == 8'h00); // RULE_04 RULE_07
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			file_we_out <= 1'b0;
			file_waddr_out <= '0;
			file_wdata_out <= '0;
		end else begin
			file_we_out <= wr_f_w;
			if (wr_f_w) begin
				file_waddr_out <= faddr_w;
				file_wdata_out <= res_reg;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			done_out <= 1'b0;
		end else begin
			done_out <= q4_w; // RULE_06
		end
	end

	// ==========================================
	// Direction registers
	// ==========================================
	// A file write from outside and one from this block never collide: the outside
	// path is only honoured while no instruction here is busy.
	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			q_phase_out <= 2'h0;
		end else begin
			q_phase_out <= q_code_w;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			dir_rdata_out <= '0;
		end else begin
			dir_rdata_out <= rd_src_w; // RULE_02
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < XADLD_NUM_DIR; gi = gi + 1) begin : g_dir
			wire ld_ins_w = q4_w && is_ldir_w && (dsel_w == 3'(gi + 5)); // RULE_01
			wire ld_res_w = q4_w && res_to_f_w && (faddr_w == 7'(gi + 5));
			wire ld_ext_w = !busy_reg && file_wr_in && (file_waddr_in == 7'(gi + 5)); // RULE_02
			wire [7:0] d_w = ld_ins_w ? w_out : (ld_res_w ? res_reg : file_wdata_in);
			xadld_dir_reg u_dir (
				.clk_in(ref_clk_in),
				.rst_n_in(rst_n_reg),
				.load_in(ld_ins_w || ld_res_w || ld_ext_w),
				.data_in(d_w),
				.value_out(dir_regs_out[8*gi +: 8])
			);
		end
	endgenerate
endmodule : xadld_core
`default_nettype wire

// ==== bench/xadld_file_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// File registers.
// Between reads the data is inverted, so a late sample cannot pass by luck.
module xadld_file_model (
	input wire logic clk_in,
	input wire logic [6:0] raddr_in,
	input wire logic rd_in,
	input wire logic we_in,
	input wire logic [6:0] waddr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [128];
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i * 37 + 11);
		end
	end
	assign rdata_out = rd_in ? mem[raddr_in] : ~mem[raddr_in];
	always @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end
endmodule : xadld_file_model
`default_nettype wire

// ==== bench/xadld_core_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks.
// Each request is assumed held for a single cycle.
module xadld_core_assertions (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic instr_valid_in,
	input wire logic [13:0] instr_in,
	input wire logic [7:0] file_rdata_in,
	input wire logic file_we_out,
	input wire logic [7:0] file_wdata_out,
	input wire logic [7:0] w_out,
	input wire logic zero_flag_out,
	input wire logic [23:0] dir_regs_out,
	input wire logic done_out
);
	import xadld_pkg::*;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	// The word is taken five edges before done is sampled, the operand three edges before it.
	logic [69:0] ir_q;
	logic [23:0] rd_q;
	logic [7:0] w_q;
	always_ff @(posedge ref_clk_in) begin
		ir_q <= {ir_q[55:0], instr_in};
		rd_q <= {rd_q[15:0], file_rdata_in};
		w_q <= w_out;
	end
	wire [13:0] ir = ir_q[69:56];
	wire [5:0] op = ir[13:8];
	wire xr = op == XADLD_XREG_OP && ir[6:3] != 4'h0;
	wire ld = (ir & XADLD_LDIR_MASK) == XADLD_LDIR_CODE;
	wire [7:0] xres = w_q ^ (xr ? rd_q[23:16] : ir[7:0]);
	take_to_done_a: assert property (
		done_out |-> $past(instr_valid_in, 5)) else $error("done without a take five cycles back");
	we_pulse_a: assert property (
		file_we_out |-> done_out ##1 !file_we_out) else $error("file write not one done cycle");
	w_at_done_a: assert property (
		$changed(w_out) |-> done_out) else $error("w moved outside write back");
	xlit_w_a: assert property (
		done_out && op == XADLD_XLIT_OP |-> w_out == xres) else $error("literal xor wrong");
	xreg_w_a: assert property (
		done_out && xr && !ir[7] |-> w_out == xres && !file_we_out) else $error("xor to w wrong");
	xreg_file_a: assert property (
		done_out && xr && ir[7] |-> file_we_out && file_wdata_out == xres && w_out == w_q) else $error("xor to file wrong");
	zero_xor_a: assert property (
		done_out && (xr || op == XADLD_XLIT_OP) |-> zero_flag_out == (xres == 8'h00)) else $error("zero flag wrong");
	dir_load_a: assert property (
		done_out && ld && ir[2:0] >= XADLD_LDIR_MIN |-> dir_regs_out[{ir[2:0] - 3'h5, 3'h0} +: 8] == w_q
		&& $stable(zero_flag_out)) else $error("direction load wrong");
	cover property (done_out && op == XADLD_XLIT_OP);
	cover property (done_out && xr && ir[7]);
	cover property (done_out && ld && ir[2:0] >= XADLD_LDIR_MIN);
endmodule : xadld_core_assertions
bind xadld_core xadld_core_assertions u_chk (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
	.instr_valid_in(instr_valid_in), .instr_in(instr_in), .file_rdata_in(file_rdata_in), .file_we_out(file_we_out),
	.file_wdata_out(file_wdata_out), .w_out(w_out), .zero_flag_out(zero_flag_out), .dir_regs_out(dir_regs_out),
	.done_out(done_out));
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench.
module testbench;
	import xadld_pkg::*;
	logic ref_clk_in = 0, reset_n_in = 0, instr_valid_in = 0, file_wr_in = 0;
	logic [13:0] instr_in = '0;
	logic [6:0] file_waddr_in = '0;
	logic [7:0] file_wdata_in = '0;
	wire [7:0] file_rdata_in, file_wdata_out, w_out, dir_rdata_out;
	wire [1:0] q_phase_out;
	wire [6:0] file_raddr_out, file_waddr_out;
	wire file_rd_out, file_we_out, zero_flag_out, done_out;
	wire [23:0] dir_regs_out;
	int err_total = 0, checked = 0, cycles = 0, seed = 28, w = 0, z = 0, s;
	logic [7:0] dir [3] = '{8'hff, 8'hff, 8'hff};
	always #2.5 ref_clk_in = ~ref_clk_in;
	xadld_core u_dut (.ref_clk_in, .reset_n_in, .instr_valid_in, .instr_in, .file_rdata_in, .file_wr_in,
		.file_waddr_in, .file_wdata_in, .file_raddr_out, .file_rd_out, .file_we_out, .file_waddr_out,
		.file_wdata_out, .w_out, .zero_flag_out, .dir_regs_out, .dir_rdata_out, .q_phase_out, .done_out);
	xadld_file_model u_file (.clk_in(ref_clk_in), .raddr_in(file_raddr_out), .rd_in(file_rd_out),
		.we_in(file_we_out), .waddr_in(file_waddr_out), .wdata_in(file_wdata_out), .rdata_out(file_rdata_in));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("compares %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	// The expected result is worked out before the answer arrives, the model state updated after it; it never reads the design.
	task automatic exec(input logic [13:0] i);
		int a, r, n;
		logic xr;
		a = i[6:0];
		xr = i[13:8] == XADLD_XREG_OP;
		@(negedge ref_clk_in);
		// A result written back by the previous call lands only on the edge just passed.
		r = w ^ (xr ? ((a >= 5 && a <= 7) ? dir[a - 5] : u_file.mem[a]) : i[7:0]);
		instr_valid_in = 1;
		instr_in = i;
		@(negedge ref_clk_in);
		instr_valid_in = 0;
		n = 0;
		while (done_out !== 1'b1 && n < 8) begin
			@(negedge ref_clk_in);
			n++;
		end
		if ((i & XADLD_LDIR_MASK) == XADLD_LDIR_CODE && i[2:0] >= 3'h5) dir[i[2:0] - 3'h5] = w[7:0];
		if (xr || i[13:8] == XADLD_XLIT_OP) z = (r == 0);
		if (i[13:8] == XADLD_XLIT_OP || (xr && !i[7])) w = r;
		chk(done_out, 1);
		chk({w_out, zero_flag_out}, {w[7:0], z[0]});
		chk(dir_regs_out, {dir[2], dir[1], dir[0]});
		chk(file_we_out, xr && i[7]);
		chk(q_phase_out, XADLD_Q4);
		if (xr && a >= 5 && a <= 7) chk(dir_rdata_out, dir[a - 5]);
		if (xr && i[7]) chk({file_waddr_out, file_wdata_out}, {i[6:0], r[7:0]});
	endtask : exec
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		repeat (16) @(negedge ref_clk_in);
		reset_n_in = 1;
		repeat (4) @(negedge ref_clk_in);
		chk(dir_regs_out, 24'hffffff);
		file_wr_in = 1;
		file_waddr_in = 7'h06;
		file_wdata_in = 8'h3c;
		@(negedge ref_clk_in);
		file_wr_in = 0;
		dir[1] = 8'h3c;
		@(negedge ref_clk_in);
		chk(dir_regs_out, {dir[2], dir[1], dir[0]});
		exec({XADLD_XREG_OP, 8'h06});
		exec({XADLD_XLIT_OP, w[7:0]});
		for (int n = 0; n < 80; n++) begin
			s = $random(seed);
			case (s[9:8])
				2'h0: exec(XADLD_LDIR_CODE | {11'h0, s[2:0]});
				2'h1: exec({XADLD_XLIT_OP, s[7:0]});
				2'h2: exec({XADLD_XREG_OP, 1'b0, s[6:0]});
				default: exec({XADLD_XREG_OP, 1'b1, s[6:3] | 4'h1, s[2:0]});
			endcase
		end
		test_done();
	end
endmodule : testbench
`default_nettype wire
